// ==== logic/adl_consts.svh ====
// Named constants for the converter dither and serial link configuration registers.
`ifndef ADL_CONSTS_SVH
`define ADL_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ADL_ADDR_W          15
`define ADL_ADDR_DITH       15'h009d
`define ADL_ADDR_MARK       15'h0160
`define ADL_ADDR_LINK_EN    15'h0200
`define ADL_ADDR_LINK_MODE  15'h0201
`define ADL_RST_DITH        8'h00
`define ADL_RST_MARK        8'h00
`define ADL_RST_LINK_EN     8'h01
`define ADL_RST_LINK_MODE   8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ADL_DITH_ON_BIT     0
`define ADL_DITH_LEVEL_BIT  1
`define ADL_DITH_ERR_BIT    2
`define ADL_MARK_ON_BIT     0
`define ADL_LINK_ON_BIT     0
`define ADL_MODE_MSB        5

// ----------------------------------------------------------------------------
// Serial port framing
// ----------------------------------------------------------------------------
`define ADL_CNT_W           5
`define ADL_CNT_HDR         5'd16
`define ADL_CNT_FRAME       5'd24
`define ADL_FRAME_W         24

// ----------------------------------------------------------------------------
// Datapath
// ----------------------------------------------------------------------------
`define ADL_CORE_W          11
`define ADL_RES_W           9
`define ADL_LINK_W          16
`define ADL_DITH_W          6
`define ADL_CORE_LAT        4
`define ADL_MARK_DLY        3
`define ADL_LFSR_SEED       16'hace1
`define ADL_MF_W            5
`define ADL_CS_W            2
`define ADL_ROUND_HALF      11'h002

`endif

// ==== logic/adl_pkg.sv ====
// Types shared by the configuration register bank and its serial port.
package adl_pkg;
    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [14:0]            addr;
        logic [7:0]             data;
    } adl_bus_req_t;

    typedef struct packed {
        logic errTarget;
        logic level;
        logic on;
    } adl_dith_cfg_t;
endpackage

// ==== logic/adl_spi_slave.sv ====
// Serial configuration port slave: frames of read bit, 15-bit address, 8-bit data.
`timescale 1ns/1ps
`include "adl_consts.svh"
module adl_spi_slave
    import adl_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         spiSclk,
    input  wire logic         spiCsN,
    input  wire logic         spiSdi,
    input  wire logic [7:0]   rdData,
    output adl_bus_req_t      busReq,
    output logic              spiSdo,
    output logic              spiSdoOe
);
    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    // The serial clock must run at no more than an eighth of clk.
    logic [2:0] sync1_q, sync2_q;
    logic       sclkOld_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q   <= 3'h7;
            sync2_q   <= 3'h7;
            sclkOld_q <= 1'b1;
        end else begin
            sync1_q   <= {spiCsN, spiSclk, spiSdi};
            sync2_q   <= sync1_q;
            sclkOld_q <= sync2_q[1];
        end
    end

    logic csActive, sclkRise, sclkFall;
    assign csActive = !sync2_q[2];
    assign sclkRise = sync2_q[1] && !sclkOld_q;
    assign sclkFall = !sync2_q[1] && sclkOld_q;

    // ------------------------------------------------------------------------
    // Shift and framing
    // ------------------------------------------------------------------------
    logic [`ADL_CNT_W-1:0]   cnt_q, cnt_d;
    logic [`ADL_FRAME_W-1:0] shift_q, shift_d;
    logic [7:0]              tx_q, tx_d;
    logic                    sdo_q, sdo_d, oe_q, oe_d;
    adl_bus_req_t            req_q, req_d;

    always_comb begin
        cnt_d   = cnt_q;
        shift_d = shift_q;
        tx_d    = tx_q;
        sdo_d   = sdo_q;
        oe_d    = oe_q;
        req_d   = '0;
        req_d.addr = req_q.addr;
        req_d.data = req_q.data;
        if (!csActive) begin
            cnt_d = '0;
            oe_d  = 1'b0;
        end else begin
            if (sclkRise && cnt_q != `ADL_CNT_FRAME) begin
                shift_d = {shift_q[`ADL_FRAME_W-2:0], sync2_q[0]};
                cnt_d   = cnt_q + 5'd1;
                if (cnt_d == `ADL_CNT_HDR && shift_d[15]) begin
                    req_d.rd   = 1'b1;
                    req_d.addr = shift_d[14:0];
                end
                if (cnt_d == `ADL_CNT_FRAME && !shift_d[23]) begin
                    req_d.wr   = 1'b1;
                    req_d.addr = shift_d[22:8];
                    req_d.data = shift_d[7:0];
                end
            end
            if (req_q.rd) begin
                tx_d = rdData;
                oe_d = 1'b1;
            end else if (sclkFall && oe_q) begin
                sdo_d = tx_q[7];
                tx_d  = {tx_q[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q   <= '0;
            shift_q <= '0;
            tx_q    <= '0;
            sdo_q   <= 1'b0;
            oe_q    <= 1'b0;
            req_q   <= '0;
        end else begin
            cnt_q   <= cnt_d;
            shift_q <= shift_d;
            tx_q    <= tx_d;
            sdo_q   <= sdo_d;
            oe_q    <= oe_d;
            req_q   <= req_d;
        end
    end

    assign busReq   = req_q;
    assign spiSdo   = sdo_q;
    assign spiSdoOe = oe_q;
endmodule

// ==== logic/adl_cfg_regs.sv ====
// Dither, sample marker and serial link configuration registers with their datapath.
`timescale 1ns/1ps
`include "adl_consts.svh"
module adl_cfg_regs
    import adl_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   spiSclk,
    input  wire logic                   spiCsN,
    input  wire logic                   spiSdi,
    output logic                        spiSdo,
    output logic                        spiSdoOe,
    input  wire logic [`ADL_CORE_W-1:0] coreSample,
    output logic [`ADL_DITH_W-1:0]      coreDither,
    input  wire logic                   markerPin,
    input  wire logic                   sysrefPin,
    output logic [`ADL_LINK_W-1:0]      linkSample,
    output logic [`ADL_CS_W-1:0]        ilaCtrlBits,
    output logic                        linkReset,
    output logic                        serializerPowerDown,
    output logic                        linkClockEnable,
    output logic [`ADL_MF_W-1:0]        multiframeCount,
    output logic [`ADL_MODE_MSB:0]      linkOutputConfig
);
    localparam int MarkLat = `ADL_CORE_LAT + 2;

    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------
    adl_bus_req_t busReq;
    logic [7:0]   rdData;

    adl_spi_slave u_spi (
        .clk      (clk),
        .rst      (rst),
        .spiSclk  (spiSclk),
        .spiCsN   (spiCsN),
        .spiSdi   (spiSdi),
        .rdData   (rdData),
        .busReq   (busReq),
        .spiSdo   (spiSdo),
        .spiSdoOe (spiSdoOe)
    );

    function automatic logic [3:0] decodeAddr(input logic [`ADL_ADDR_W-1:0] a);
        logic [3:0] sel;
        sel = 4'h0;
        sel[0] = (a == `ADL_ADDR_DITH);
        sel[1] = (a == `ADL_ADDR_MARK);
        sel[2] = (a == `ADL_ADDR_LINK_EN);
        sel[3] = (a == `ADL_ADDR_LINK_MODE);
        return sel;
    endfunction

    // Reserved bits are stored and read back as written; the host keeps them at reset value.
    logic [7:0] dith_q, dith_d, mark_q, mark_d, lnkEn_q, lnkEn_d, mode_q, mode_d;
    logic [3:0] wrSel, rdSel;
    assign wrSel = busReq.wr ? decodeAddr(busReq.addr) : 4'h0;
    assign rdSel = decodeAddr(busReq.addr);

    always_comb begin
        dith_d  = wrSel[0] ? busReq.data : dith_q;
        mark_d  = wrSel[1] ? busReq.data : mark_q;
        lnkEn_d = wrSel[2] ? busReq.data : lnkEn_q;
        mode_d  = wrSel[3] ? busReq.data : mode_q;
        rdData  = ({8{rdSel[0]}} & dith_q) | ({8{rdSel[1]}} & mark_q)
                | ({8{rdSel[2]}} & lnkEn_q) | ({8{rdSel[3]}} & mode_q);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dith_q  <= `ADL_RST_DITH;
            mark_q  <= `ADL_RST_MARK;
            lnkEn_q <= `ADL_RST_LINK_EN;
            mode_q  <= `ADL_RST_LINK_MODE;
        end else begin
            dith_q  <= dith_d;
            mark_q  <= mark_d;
            lnkEn_q <= lnkEn_d;
            mode_q  <= mode_d;
        end
    end

    adl_dith_cfg_t dithCfg;
    logic          markerOn, linkOn;
    assign dithCfg  = {dith_q[`ADL_DITH_ERR_BIT], dith_q[`ADL_DITH_LEVEL_BIT],
                       dith_q[`ADL_DITH_ON_BIT]};
    assign markerOn = mark_q[`ADL_MARK_ON_BIT];
    assign linkOn   = lnkEn_q[`ADL_LINK_ON_BIT];

    assign linkOutputConfig    = mode_q[`ADL_MODE_MSB:0];
    assign linkReset           = !linkOn;
    assign serializerPowerDown = !linkOn;
    assign linkClockEnable     = linkOn;
    assign ilaCtrlBits         = '0;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [1:0] pinS1_q, pinS2_q;
    logic       sysrefOld_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            pinS1_q     <= 2'h0;
            pinS2_q     <= 2'h0;
            sysrefOld_q <= 1'b0;
        end else begin
            pinS1_q     <= {sysrefPin, markerPin};
            pinS2_q     <= pinS1_q;
            sysrefOld_q <= pinS2_q[1];
        end
    end

    // ------------------------------------------------------------------------
    // Dither generation and subtraction
    // ------------------------------------------------------------------------
    // Dither is counted in LSB steps of the core word, a quarter of a converter LSB, so it is removed exactly
    // apart from the final rounding to converter resolution.
    logic [15:0]                         lfsr_q, lfsr_d;
    logic [`ADL_DITH_W-1:0]              dithOut_q, dithOut_d;
    logic [`ADL_DITH_W-1:0]              dithPipe_q [`ADL_CORE_LAT];
    logic [`ADL_CORE_W-1:0]              corrected, rounded;
    logic [`ADL_RES_W-1:0]               res_q, res_d;

    always_comb begin
        lfsr_d    = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
        dithOut_d = '0;
        if (dithCfg.on) begin
            dithOut_d = dithCfg.level ? lfsr_q[5:0] : {3'h0, lfsr_q[2:0]};
        end
        corrected = coreSample - {5'h00, dithPipe_q[`ADL_CORE_LAT-1]};
        // Random rounding spreads the error as noise; a fixed half step biases DC.
        if (dithCfg.errTarget) begin
            rounded = corrected + `ADL_ROUND_HALF;
        end else begin
            rounded = corrected + {9'h000, lfsr_q[7:6]};
        end
        res_d = rounded[`ADL_CORE_W-1:`ADL_CORE_W-`ADL_RES_W];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lfsr_q    <= `ADL_LFSR_SEED;
            dithOut_q <= '0;
            res_q     <= '0;
        end else begin
            lfsr_q    <= lfsr_d;
            dithOut_q <= dithOut_d;
            res_q     <= res_d;
        end
    end
    assign coreDither = dithOut_q;

    // ------------------------------------------------------------------------
    // Delay lines
    // ------------------------------------------------------------------------
    logic [`ADL_MARK_DLY-1:0] markPipe_q;
    genvar g;
    generate
        for (g = 0; g < `ADL_CORE_LAT; g++) begin : g_dith
            always_ff @(posedge clk) begin
                if (rst) begin
                    dithPipe_q[g] <= '0;
                end else begin
                    dithPipe_q[g] <= (g == 0) ? dithOut_q : dithPipe_q[(g == 0) ? 0 : g - 1];
                end
            end
        end
        for (g = 0; g < `ADL_MARK_DLY; g++) begin : g_mark
            always_ff @(posedge clk) begin
                if (rst) begin
                    markPipe_q[g] <= 1'b0;
                end else begin
                    markPipe_q[g] <= (g == 0) ? pinS2_q[0] : markPipe_q[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Link sample and multiframe counter
    // ------------------------------------------------------------------------
    logic [`ADL_LINK_W-1:0] link_q, link_d;
    logic [`ADL_MF_W-1:0]   mf_q, mf_d;

    always_comb begin
        link_d = '0;
        mf_d   = '0;
        if (linkOn) begin
            link_d = {res_q, 6'h00, markerOn & markPipe_q[`ADL_MARK_DLY-1]};
            if (!(pinS2_q[1] && !sysrefOld_q)) begin
                mf_d = mf_q + 5'd1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            link_q <= '0;
            mf_q   <= '0;
        end else begin
            link_q <= link_d;
            mf_q   <= mf_d;
        end
    end
    assign linkSample      = link_q;
    assign multiframeCount = mf_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    AST_DITH_OFF: assert property (@(posedge clk) disable iff (rst)
        !dithCfg.on |=> coreDither == '0) else $error("dither present while off");
    AST_DITH_SMALL: assert property (@(posedge clk) disable iff (rst)
        dithCfg.on && !dithCfg.level |=> coreDither[5:3] == 3'h0)
        else $error("small dither too large");
    AST_MARK_OFF: assert property (@(posedge clk) disable iff (rst)
        !markerOn |=> !linkSample[0]) else $error("marker bit set while off");
    AST_MARK_LAT: assert property (@(posedge clk) disable iff (rst)
        $past(markerOn) && $past(linkOn) && !$past(rst, MarkLat)
        |-> linkSample[0] == $past(markerPin, MarkLat)) else $error("marker latency wrong");
    AST_LSB_KEEP: assert property (@(posedge clk) disable iff (rst)
        linkOn |=> linkSample[6:1] == 6'h00 && linkSample[15:7] == $past(res_q))
        else $error("converter bits displaced");
    AST_CS_ZERO: assert property (@(posedge clk) disable iff (rst)
        ilaCtrlBits == '0) else $error("control bit count advertised");
    AST_LINK_RST: assert property (@(posedge clk)
        $fell(rst) |-> linkOn && linkClockEnable) else $error("link not enabled at reset");
    AST_LINK_OFF: assert property (@(posedge clk) disable iff (rst)
        !linkOn |-> (linkReset && serializerPowerDown && !linkClockEnable)
        ##1 (linkSample == '0)) else $error("link active while disabled");
    AST_MF_HOLD: assert property (@(posedge clk) disable iff (rst)
        !linkOn |=> multiframeCount == '0) else $error("multiframe counter runs while off");
    AST_MODE_WR: assert property (@(posedge clk) disable iff (rst)
        busReq.wr && busReq.addr == `ADL_ADDR_LINK_MODE
        |=> linkOutputConfig == $past(busReq.data[5:0])) else $error("mode not updated");
endmodule

// ==== tb/adl_host_model.sv ====
// Host model that drives the serial configuration port of the register bank.
`timescale 1ns/1ps
module adl_host_model (
    input  wire logic clk,
    output logic      spiSclk,
    output logic      spiCsN,
    output logic      spiSdi,
    input  wire logic spiSdo
);
    // Each serial clock phase lasts five system clocks, one above the port's minimum.
    localparam int HALF = 5;

    initial begin
        spiSclk = 1'b0;
        spiCsN  = 1'b1;
        spiSdi  = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------
    task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                        output logic [7:0] rdv);
        logic [23:0] f;
        f = {rd, addr, wd};
        rdv = 8'h00;
        @(posedge clk);
        spiCsN <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spiSdi <= f[i];
            repeat (HALF) @(posedge clk);
            spiSclk <= 1'b1;
            if (i < 8)
                rdv[i] = spiSdo;
            repeat (HALF) @(posedge clk);
            spiSclk <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        spiCsN <= 1'b1;
        // Outside a frame the data line means nothing, so it is toggled for six clocks after the frame.
        repeat (6) @(posedge clk)
            spiSdi <= ~spiSdi;
    endtask
endmodule

// ==== tb/adc_dither_and_link_config_regs_bench.sv ====
// Self-checking bench for the configuration register bank and its datapath.
`timescale 1ns/1ps
`include "adl_consts.svh"
module adc_dither_and_link_config_regs_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        spiSclk, spiCsN, spiSdi, spiSdo, spiSdoOe;
    logic [10:0] coreSample = 11'h000;
    logic        markerPin = 1'b0;
    logic        sysrefPin = 1'b0;
    logic [5:0]  coreDither, linkOutputConfig;
    logic [15:0] linkSample;
    logic [1:0]  ilaCtrlBits;
    logic [4:0]  multiframeCount;
    logic        linkReset, serializerPowerDown, linkClockEnable;
    int          fails = 0, samples_checked = 0, seed = 32'h3317c1eb;
    int          base = 64, cnt = 0, dMax = 0, bh[4], mh[8], dh[4];
    logic        chk = 1'b0, mkOn = 1'b0;
    logic [7:0]  dcfg = 8'h00;
    // A released data line floats high through the board's pull-up.
    wire         sdoLine = spiSdoOe ? spiSdo : 1'b1;
    wire [4:0]   linkStat = {linkReset, serializerPowerDown, linkClockEnable, ilaCtrlBits};

    always #20 clk = ~clk;

    adl_host_model host_u (.clk, .spiSclk, .spiCsN, .spiSdi, .spiSdo (sdoLine));

    adl_cfg_regs dut_u (.clk, .rst, .spiSclk, .spiCsN, .spiSdi, .spiSdo, .spiSdoOe,
        .coreSample, .coreDither, .markerPin, .sysrefPin, .linkSample, .ilaCtrlBits,
        .linkReset, .serializerPowerDown, .linkClockEnable, .multiframeCount,
        .linkOutputConfig);

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic endtest(input string n);
        $display("test %s finished, mismatches so far %0d", n, fails);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] x;
        host_u.xfer(1'b0, a, d, x);
        repeat (8) @(posedge clk);
    endtask

    task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] x;
        host_u.xfer(1'b1, a, 8'h00, x);
        cmp("regRead", e, x);
    endtask

    // Sync pulses are thrown in only while the link is off, where they must be ignored.
    task automatic linkchk(input logic on, input int n);
        logic [4:0] m;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            m = multiframeCount;
            sysrefPin <= on ? 1'b0 : 1'(i % 3 == 0);
            cmp("linkState", {~on, ~on, on, 2'b00}, linkStat);
            if (!on)
                cmp("linkHeld", 0, {multiframeCount, linkSample});
            @(posedge clk);
            if (on)
                cmp("mfStep", 5'(m + 5'd1), multiframeCount);
        end
    endtask

    // ------------------------------------------------------------
    // Core emulation and reference model
    // ------------------------------------------------------------
    // The core adds the dither it was given four clocks earlier, as the converter does.
    always @(posedge clk) begin
        int e;
        for (int i = 7; i > 0; i--)
            mh[i] = mh[i-1];
        for (int i = 3; i > 0; i--) begin
            bh[i] = bh[i-1];
            dh[i] = dh[i-1];
        end
        mh[0] = markerPin;
        bh[0] = base;
        dh[0] = coreDither;
        if (chk) begin
            e = (bh[2] + 2) >> 2;
            if (!dcfg[2] && linkSample[15:7] === 9'((bh[2] + 3) >> 2))
                e = (bh[2] + 3) >> 2;
            else if (!dcfg[2])
                e = bh[2] >> 2;
            if (bh[1] == bh[2] && bh[2] == bh[3])
                cmp("linkData", {e[8:0], 7'h00}, {linkSample[15:1], 1'b0});
            if (mh[5] == mh[6] && mh[6] == mh[7])
                cmp("linkMarker", mkOn & mh[6], linkSample[0]);
            cmp("ditherRange", 1, coreDither <= (!dcfg[0] ? 0 : dcfg[1] ? 63 : 7));
            if (coreDither > dMax)
                dMax = coreDither;
        end
        cnt++;
        if (cnt % 4 == 0)
            base = 64 + {$random(seed)} % 1920;
        coreSample <= 11'(base + dh[3]);
        if (cnt % 8 == 0)
            markerPin <= 1'($random(seed));
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [14:0] ra[4];
        logic [7:0]  rr[4];
        logic [7:0]  dt[5];
        logic [31:0] g;
        ra = '{`ADL_ADDR_DITH, `ADL_ADDR_MARK, `ADL_ADDR_LINK_EN, `ADL_ADDR_LINK_MODE};
        rr = '{`ADL_RST_DITH, `ADL_RST_MARK, `ADL_RST_LINK_EN, `ADL_RST_LINK_MODE};
        dt = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h00};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++)
            rdchk(ra[i], rr[i]);
        wr(15'h0123, 8'h5a);
        rdchk(15'h0123, 8'h00);
        linkchk(1'b1, 20);
        endtest("reset");
        wr(`ADL_ADDR_LINK_EN, 8'h00);
        linkchk(1'b0, 20);
        for (int i = 0; i < 3; i++) begin
            g = (i == 0) ? 32'h3f : {$random(seed)} % 64;
            wr(`ADL_ADDR_LINK_MODE, g[7:0]);
            rdchk(`ADL_ADDR_LINK_MODE, g[7:0]);
            cmp("linkOutputConfig", g, linkOutputConfig);
        end
        endtest("linkOff");
        wr(`ADL_ADDR_LINK_EN, 8'h01);
        linkchk(1'b1, 20);
        endtest("linkOn");
        for (int i = 0; i < 5; i++) begin
            dcfg = dt[i];
            mkOn = (i != 1);
            wr(`ADL_ADDR_DITH, dcfg);
            wr(`ADL_ADDR_MARK, {7'h00, mkOn});
            rdchk(`ADL_ADDR_DITH, dcfg);
            rdchk(`ADL_ADDR_MARK, {7'h00, mkOn});
            @(negedge clk);
            dMax = 0;
            chk = 1'b1;
            repeat (150) @(posedge clk);
            @(negedge clk);
            chk = 1'b0;
            cmp("ditherUsed", dcfg[0], dMax > 0);
            cmp("ditherLarge", dcfg[1] & dcfg[0], dMax > 7);
            endtest("datapath");
        end
        give_verdict();
    end

    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        give_verdict();
    end
endmodule
